// >>> pkg/pps_consts.svh
// timing counts, reset values and codes of the parameter port block
// assumes a single 10 MHz system clock; counts are whole clock cycles
`ifndef PPS_CONSTS_SVH
`define PPS_CONSTS_SVH

// system clock period in ns
`define PPS_CLK_PERIOD_NS 100
// least strobe pulse width in ns
`define PPS_PULSE_MIN_NS 6000
// least delay from new output data to input sampling in ns
`define PPS_SAMPLE_MIN_NS 10500
// least delay from strobe fall to pin release in ns
`define PPS_OFF_MIN_NS 56000
// latest data valid point after strobe fall in ns
`define PPS_VALID_MAX_NS 1500
// least time rounded up to whole cycles
`define PPS_CYC_UP(ns) (((ns) + `PPS_CLK_PERIOD_NS - 1) / `PPS_CLK_PERIOD_NS)
// cycle counts derived from the times above
`define PPS_PULSE_CYC `PPS_CYC_UP(`PPS_PULSE_MIN_NS)
`define PPS_SAMPLE_CYC `PPS_CYC_UP(`PPS_SAMPLE_MIN_NS)
`define PPS_OFF_CYC `PPS_CYC_UP(`PPS_OFF_MIN_NS)
// width of the interval counter
`define PPS_CNT_W 10
// output register value after reset
`define PPS_OUT_RESET 4'hF
// io configuration code that releases the pins after each write
`define PPS_IO_CODE_REL 4'h7

`endif

// >>> pkg/pps_pkg.sv
// types shared by the parameter port block
// assumes the constants header is compiled alongside
package pps_pkg;
  // four-bit parameter nibble
  typedef logic [3:0] pps_nib_t;
  // sequencer states
  typedef enum logic [2:0] {
    PPS_ST_START,   // reset strobe pending
    PPS_ST_IDLE,    // waiting for a write request
    PPS_ST_PULSE,   // strobe low
    PPS_ST_SAMPLE,  // waiting for the sampling point
    PPS_ST_RELEASE  // waiting to release the pins
  } pps_state_e;
endpackage : pps_pkg

// >>> pkg/pps_tmr_if.sv
// link between the sequencer and its interval counter
// assumes both ends run on the same clock
interface pps_tmr_if #(
  parameter int CNT_W = 10
);
  logic clear;              // restart counting from zero
  logic [CNT_W-1:0] count;  // cycles since the last clear
  modport ctl (output clear, input count);
  modport tmr (input clear, output count);
endinterface : pps_tmr_if

// >>> hdl/pps_timer.sv
// interval counter for strobe, sampling and release timing
// assumes clear is synchronous; the count saturates at all ones
module pps_timer #(
  parameter int CNT_W = 10  // counter width
) (
  input wire logic clk,      // system clock
  input wire logic resetn,   // asynchronous reset, active low
  pps_tmr_if.tmr tmr         // clear in, count out
);
  logic [CNT_W-1:0] count_q;  // cycles since last clear

  // count system clock cycles from each clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= '0;
    end else if (tmr.clear) begin
      count_q <= '0;
    end else if (count_q != {CNT_W{1'b1}}) begin
      count_q <= count_q + CNT_W'(1);
    end
  end

  assign tmr.count = count_q;
endmodule : pps_timer

// >>> hdl/pps_port.sv
// parameter port sequencer: output register, open-drain pins, strobe,
// input sampling, release in io configuration 7, exchange enable
// assumes a 10 MHz clock and synchronous pin inputs
`include "pps_consts.svh"

// Summary of operation
// - bidirectional port; code 7 releases after write
// - load value, drive pins open-drain low only
// - sample inputs 10.5 to 12.5 us later
// - sampled bit is wired AND of levels
// - active-low strobe 6.0 to 6.8 us
// - data valid within 1.5 us of fall
// - first write enables data exchange
// - reset loads all ones, pins released
// - reset issues a normal strobe too
// - code 7 release 56.0 to 64.5 us
module pps_port #(
  parameter int PULSE_CYC = `PPS_PULSE_CYC,    // strobe width in cycles
  parameter int SAMPLE_CYC = `PPS_SAMPLE_CYC,  // sampling delay in cycles
  parameter int OFF_CYC = `PPS_OFF_CYC,        // release delay in cycles
  parameter int CNT_W = `PPS_CNT_W             // interval counter width
) (
  input wire logic clk,                        // system clock, 10 MHz
  input wire logic resetn,                     // async reset, active low
  input wire logic wr_req_i,                   // write parameter request
  input wire pps_pkg::pps_nib_t wr_data_i,     // parameter value to write
  input wire logic [3:0] io_code_i,            // io configuration code
  input wire pps_pkg::pps_nib_t param_pins_i,  // pin levels as seen
  output logic [3:0] param_pins_o,             // pin drive value, always 0
  output logic [3:0] param_pins_oe_n,          // pin pulls low when 0
  output logic param_update_pulse_n,           // strobe, active low
  output pps_pkg::pps_nib_t param_out_q,       // parameter output register
  output pps_pkg::pps_nib_t param_in_q,        // sampled parameter input
  output logic param_in_valid_q,               // one-cycle sample pulse
  output logic dexg_enable_q                   // data exchange permitted
);
  import pps_pkg::*;

  localparam logic [CNT_W-1:0] PULSE_END = CNT_W'(PULSE_CYC - 1);
  localparam logic [CNT_W-1:0] SAMPLE_END = CNT_W'(SAMPLE_CYC - 1);
  localparam logic [CNT_W-1:0] OFF_END = CNT_W'(OFF_CYC - 1);

  pps_state_e state_q;   // sequencer state
  logic ev;              // new output event this cycle
  logic pulse_n_q;       // strobe flop
  logic drive_q;         // pins are being driven
  logic io7_q;           // release mode latched at write
  logic [3:0] oe_n_q;    // per-pin enable flops
  logic sample_hit;      // sampling point reached
  logic release_hit;     // release point reached

  pps_tmr_if #(.CNT_W(CNT_W)) tmr_if ();

  // interval counter restarted on every output event
  pps_timer #(.CNT_W(CNT_W)) u_timer (
    .clk(clk),
    .resetn(resetn),
    .tmr(tmr_if.tmr)
  );

  // a write, or the pending reset strobe, starts an output event
  assign ev = wr_req_i || (state_q == PPS_ST_START);
  assign tmr_if.clear = ev;
  assign sample_hit = (state_q == PPS_ST_SAMPLE)
                      && (tmr_if.count == SAMPLE_END);
  assign release_hit = (state_q == PPS_ST_RELEASE)
                       && (tmr_if.count == OFF_END);

  // sequencer; a new write restarts the sequence at once
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= PPS_ST_START;
    end else if (ev) begin
      state_q <= PPS_ST_PULSE;
    end else begin
      unique case (state_q)
        PPS_ST_START, PPS_ST_IDLE: begin
          state_q <= state_q;
        end
        PPS_ST_PULSE: begin
          // strobe done, wait for the sampling point
          if (tmr_if.count == PULSE_END) begin
            state_q <= PPS_ST_SAMPLE;
          end
        end
        PPS_ST_SAMPLE: begin
          // after sampling, release only in configuration 7
          if (sample_hit) begin
            state_q <= io7_q ? PPS_ST_RELEASE : PPS_ST_IDLE;
          end
        end
        PPS_ST_RELEASE: begin
          if (release_hit) begin
            state_q <= PPS_ST_IDLE;
          end
        end
      endcase
    end
  end

  // strobe falls with each event and rises after the pulse width
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pulse_n_q <= 1'b1;
    end else if (ev) begin
      pulse_n_q <= 1'b0;
    end else if (state_q == PPS_ST_PULSE && tmr_if.count == PULSE_END) begin
      pulse_n_q <= 1'b1;
    end
  end

  // parameter output register and drive state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      param_out_q <= `PPS_OUT_RESET;
      drive_q <= 1'b0;
      io7_q <= 1'b0;
    end else if (wr_req_i) begin
      param_out_q <= wr_data_i;
      drive_q <= 1'b1;
      io7_q <= (io_code_i == `PPS_IO_CODE_REL);
    end else if (release_hit) begin
      drive_q <= 1'b0;
    end
  end

  // per-pin open-drain enable: pull low only where the bit is zero
  for (genvar i = 0; i < 4; i++) begin : g_pin
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        oe_n_q[i] <= 1'b1;
      end else if (wr_req_i) begin
        oe_n_q[i] <= wr_data_i[i];
      end else if (release_hit) begin
        oe_n_q[i] <= 1'b1;
      end
    end
  end

  // input sampling as wired AND of own drive and outside levels
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      param_in_q <= `PPS_OUT_RESET;
      param_in_valid_q <= 1'b0;
    end else begin
      param_in_valid_q <= sample_hit;
      if (sample_hit) begin
        param_in_q <= param_pins_i & (drive_q ? param_out_q : 4'hF);
      end
    end
  end

  // data exchange stays off until the first write after reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dexg_enable_q <= 1'b0;
    end else if (wr_req_i) begin
      dexg_enable_q <= 1'b1;
    end
  end

  assign param_pins_o = 4'h0;
  assign param_pins_oe_n = oe_n_q;
  assign param_update_pulse_n = pulse_n_q;

  // helper: cycles since the strobe fall, independent of the timer
  logic ev_q;
  logic [CNT_W-1:0] hlp_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ev_q <= 1'b0;
      hlp_q <= '0;
    end else begin
      ev_q <= ev;
      if (ev_q) begin
        hlp_q <= CNT_W'(1);
      end else if (hlp_q != {CNT_W{1'b1}}) begin
        hlp_q <= hlp_q + CNT_W'(1);
      end
    end
  end

  property p_pulse_width;
    @(posedge clk) disable iff (!resetn)
    $rose(param_update_pulse_n) |-> hlp_q == CNT_W'(PULSE_CYC);
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("strobe width wrong");

  property p_data_valid;
    @(posedge clk) disable iff (!resetn)
    $fell(param_update_pulse_n) && drive_q |->
      param_pins_oe_n == param_out_q;
  endproperty
  a_data_valid: assert property (p_data_valid)
    else $error("data not valid at strobe fall");

  property p_load;
    @(posedge clk) disable iff (!resetn)
    wr_req_i |=> param_out_q == $past(wr_data_i) && drive_q
      && !param_update_pulse_n;
  endproperty
  a_load: assert property (p_load)
    else $error("write not loaded");

  property p_sample_time;
    @(posedge clk) disable iff (!resetn)
    param_in_valid_q |-> hlp_q == CNT_W'(SAMPLE_CYC);
  endproperty
  a_sample_time: assert property (p_sample_time)
    else $error("sample at wrong time");

  property p_sample_and;
    @(posedge clk) disable iff (!resetn)
    param_in_valid_q && $past(drive_q) |->
      (param_in_q & ~$past(param_out_q)) == 4'h0;
  endproperty
  a_sample_and: assert property (p_sample_and)
    else $error("sample not wired AND");

  property p_release_time;
    @(posedge clk) disable iff (!resetn)
    $fell(drive_q) |-> $past(io7_q) && hlp_q == CNT_W'(OFF_CYC)
      && param_pins_oe_n == 4'hF;
  endproperty
  a_release_time: assert property (p_release_time)
    else $error("release wrong");

  property p_keep_drive;
    @(posedge clk) disable iff (!resetn)
    drive_q && !io7_q && !wr_req_i |=> drive_q;
  endproperty
  a_keep_drive: assert property (p_keep_drive)
    else $error("pins released outside configuration 7");

  property p_enable;
    @(posedge clk) disable iff (!resetn)
    $rose(dexg_enable_q) |-> $past(wr_req_i) ##1 dexg_enable_q;
  endproperty
  a_enable: assert property (p_enable)
    else $error("exchange enable wrong");

  property p_reset_strobe;
    @(posedge clk) disable iff (!resetn)
    $fell(param_update_pulse_n) && !drive_q |->
      param_out_q == 4'hF && param_pins_oe_n == 4'hF;
  endproperty
  a_reset_strobe: assert property (p_reset_strobe)
    else $error("reset strobe state wrong");

  property p_cov_reset;
    @(posedge clk) disable iff (!resetn)
    !drive_q && $rose(param_update_pulse_n);
  endproperty
  c_cov_reset: cover property (p_cov_reset);

  property p_cov_release;
    @(posedge clk) disable iff (!resetn)
    $fell(drive_q);
  endproperty
  c_cov_release: cover property (p_cov_release);

  property p_cov_sample;
    @(posedge clk) disable iff (!resetn)
    param_in_valid_q && drive_q;
  endproperty
  c_cov_sample: cover property (p_cov_sample);

  property p_cov_restart;
    @(posedge clk) disable iff (!resetn)
    wr_req_i && state_q == PPS_ST_PULSE;
  endproperty
  c_cov_restart: cover property (p_cov_restart);
endmodule : pps_port

// >>> tb/pps_ext_model.sv
// outside circuitry on the four open-drain parameter pins
// assumes pull-ups on every pin; the bench says which pins it pulls low
module pps_ext_model (
  input wire logic [3:0] ext_lvl,  // outside level, 1 = released
  input wire logic [3:0] pin_o,    // device drive value
  input wire logic [3:0] pin_oe_n, // device pulls low where 0
  output logic [3:0] pin_lvl       // resolved pin level
);
  timeunit 1ns;
  timeprecision 1ns;
  // wired AND; ext_lvl moves only between sequences, so it stays put
  // across the whole sampling window
  assign pin_lvl = ext_lvl & (pin_oe_n | pin_o);
endmodule : pps_ext_model

// >>> tb/pps_port_test.sv
// self-checking bench for the parameter port sequencer
// assumes default interval counts: 60, 105 and 560 cycles
module pps_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  import pps_pkg::*;
  logic clk, resetn, wr_req_i;
  pps_nib_t wr_data_i, param_pins_i, ext_lvl, param_out_q, param_in_q;
  logic [3:0] io_code_i, param_pins_o, param_pins_oe_n;
  logic param_update_pulse_n, param_in_valid_q, dexg_enable_q;
  int miscompares = 0;   // failed comparisons
  int total_checks = 0;  // all comparisons

  pps_port dut (.clk(clk), .resetn(resetn), .wr_req_i(wr_req_i),
    .wr_data_i(wr_data_i), .io_code_i(io_code_i),
    .param_pins_i(param_pins_i), .param_pins_o(param_pins_o),
    .param_pins_oe_n(param_pins_oe_n),
    .param_update_pulse_n(param_update_pulse_n),
    .param_out_q(param_out_q), .param_in_q(param_in_q),
    .param_in_valid_q(param_in_valid_q), .dexg_enable_q(dexg_enable_q));

  pps_ext_model ext (.ext_lvl(ext_lvl), .pin_o(param_pins_o),
    .pin_oe_n(param_pins_oe_n), .pin_lvl(param_pins_i));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // count one comparison, report it if it failed
  task chk(input bit ok, input string msg);
    total_checks++;
    if (!ok) begin
      miscompares++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask : chk

  task finish_test;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  // follow one strobe sequence for 600 cycles and judge its events;
  // entered just after the edge before the one that starts it
  task automatic run_seq(input pps_nib_t d, input logic rel,
                         input logic en);
    int rise = 0;
    int vcnt = 0;
    int vn = 0;
    int chg = 0;
    pps_nib_t vin = 4'h0;
    for (int n = 1; n <= 600; n++) begin
      @(posedge clk);
      #10;
      if (n == 1) begin
        wr_req_i = 1'b0;
        chk(param_out_q === d && param_pins_oe_n === d, "pin data");
        chk(param_update_pulse_n === 1'b0, "strobe not low");
        chk(param_pins_o === 4'h0, "drive not low only");
      end
      if (param_update_pulse_n === 1'b1 && rise == 0) rise = n;
      if (param_in_valid_q === 1'b1) begin
        vcnt++;
        vn = n;
        vin = param_in_q;
      end
      if (n > 1 && param_pins_oe_n !== d && chg == 0) chg = n;
    end
    chk(rise == 61, "strobe width");
    chk(vcnt == 1 && vn == 106, "sample time");
    chk(vin === (d & ext_lvl), "sampled value");
    chk(chg == (rel ? 561 : 0), "release time");
    chk(!rel || param_pins_oe_n === 4'hF, "pins not released");
    chk(dexg_enable_q === en, "exchange enable");
  endtask : run_seq

  // reset, values held in reset, then the reset strobe
  task t_reset(input pps_nib_t e);
    ext_lvl = e;
    resetn = 1'b0;
    repeat (6) @(posedge clk);
    #10;
    chk(param_pins_oe_n === 4'hF && param_out_q === 4'hF, "reset");
    chk(dexg_enable_q === 1'b0, "enable in reset");
    chk(param_update_pulse_n === 1'b1, "strobe in reset");
    resetn = 1'b1;
    run_seq(4'hF, 1'b0, 1'b0);
    $display("test reset done");
  endtask : t_reset

  // one write request with a given outside level
  task t_write(input pps_nib_t d, input logic [3:0] code,
               input pps_nib_t e);
    ext_lvl = e;
    wr_data_i = d;
    io_code_i = code;
    wr_req_i = 1'b1;
    run_seq(d, code == 4'h7, 1'b1);
    $display("test write %h code %h done", d, code);
  endtask : t_write

  // back-to-back requests: the second drops the first's release
  task t_restart;
    ext_lvl = 4'hB;
    wr_data_i = 4'h3;
    io_code_i = 4'h7;
    wr_req_i = 1'b1;
    @(posedge clk);
    #10;
    wr_data_i = 4'hC;
    io_code_i = 4'h0;
    run_seq(4'hC, 1'b0, 1'b1);
    $display("test restart done");
  endtask : t_restart

  // main sequence
  initial begin
    wr_req_i = 1'b0;
    wr_data_i = 4'h0;
    io_code_i = 4'h0;
    t_reset(4'hF);
    t_write(4'hA, 4'h3, 4'h6);
    t_write(4'h5, 4'h7, 4'hF);
    t_write(4'h0, 4'h7, 4'hE);
    t_restart();
    t_reset(4'h9);
    finish_test();
  end

  // watchdog: the tests need about 0.36 ms
  initial begin
    #1000000;
    miscompares++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule : pps_port_test
